// >>> core/lph_consts.svh
`ifndef LPH_CONSTS_SVH
`define LPH_CONSTS_SVH

// ----------------------------------------------------------------------------
// Opcode decoding
// ----------------------------------------------------------------------------
`define LPH_OPC_HI 8'h75
`define LPH_OPC_HI_MSB 15
`define LPH_OPC_HI_LSB 8
`define LPH_IND_BIT 7
`define LPH_DMA_MSB 6

// ----------------------------------------------------------------------------
// Product register layout and reset values
// ----------------------------------------------------------------------------
`define LPH_PROD_HI_MSB 31
`define LPH_PROD_HI_LSB 16
`define LPH_PROD_RST 32'h0000_0000

// ----------------------------------------------------------------------------
// Timing counts, in core cycles
// ----------------------------------------------------------------------------
`define LPH_BASE_CYC 16'h0001
`define LMR_CORE_PER_N 16'h0002
`define LMR_PORT_PER_N 16'h0003
`define LMR_PORT_CODE_EXT 16'h0003
`define LPH_ONE_CYC 16'h0001

`endif

// >>> core/lph_pkg.sv
package lph_pkg;

  // --------------------------------------------------------------------------
  // Memory kinds, destinations, states and the cycle count type
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    LPH_MEM_ROM = 2'b00,
    LPH_MEM_DUAL = 2'b01,
    LPH_MEM_SINGLE = 2'b10,
    LPH_MEM_EXT = 2'b11
  } lph_mem_t;

  typedef enum logic [1:0] {
    LPH_DST_CORE = 2'b00,
    LPH_DST_PERIPH = 2'b01,
    LPH_DST_PORT = 2'b10
  } lph_dst_t;

  typedef enum logic [1:0] {
    LPH_ST_IDLE = 2'b00,
    LPH_ST_RUN = 2'b01,
    LPH_ST_DONE = 2'b10
  } lph_state_t;

  typedef logic [15:0] lph_cyc_t;

endpackage : lph_pkg

// >>> core/lph_cycle_calc.sv
`timescale 1ns/100ps
`include "lph_consts.svh"

module lph_cycle_calc (
  // Instruction class and repeat count.
  input wire logic is_lmr_i,
  input wire logic [8:0] rep_n_i,
  // Where code, operand and destination live.
  input wire lph_pkg::lph_mem_t code_loc_i,
  input wire lph_pkg::lph_mem_t src_loc_i,
  input wire logic same_block_i,
  input wire lph_pkg::lph_dst_t dst_kind_i,
  // Wait states per access.
  input wire logic [3:0] data_wait_i,
  input wire logic [3:0] code_wait_i,
  input wire logic [3:0] io_wait_i,
  // Total cycle count.
  output lph_pkg::lph_cyc_t cycles_o
);
  import lph_pkg::*;

  // Scales a per-iteration count by the repeat count.
  function automatic lph_cyc_t times_n(input lph_cyc_t per, input logic [8:0] n);
    logic [24:0] prod;
    prod = per * n;
    return prod[15:0];
  endfunction : times_n

  wire lph_cyc_t n_w = {7'h00, rep_n_i};
  wire logic src_ext_w = (src_loc_i == LPH_MEM_EXT);
  wire logic code_ext_w = (code_loc_i == LPH_MEM_EXT);
  wire logic both_ext_w = src_ext_w & code_ext_w;
  wire logic shared_w = same_block_i & (src_loc_i == LPH_MEM_SINGLE)
                        & (code_loc_i == LPH_MEM_SINGLE);
  wire lph_cyc_t d_w = {12'h000, data_wait_i};
  wire lph_cyc_t p_w = {12'h000, code_wait_i};
  wire lph_cyc_t io_w = {12'h000, io_wait_i};
  wire logic port_w = (dst_kind_i == LPH_DST_PORT);
  wire lph_cyc_t sh_w = shared_w ? `LPH_ONE_CYC : 16'h0000;

  // Load-product-high: n, plus n*d for outside operands, p for outside code.
  // single timing
  wire lph_cyc_t lph_cyc_w = times_n(`LPH_BASE_CYC, rep_n_i)
                             + (src_ext_w ? times_n(d_w, rep_n_i) : 16'h0000)
                             + (code_ext_w ? p_w : 16'h0000)
                             + (both_ext_w ? `LPH_ONE_CYC : 16'h0000) + sh_w;

  // Mapped load into core or peripheral registers.
  // core register timing
  wire lph_cyc_t core_cyc_w = times_n(`LMR_CORE_PER_N, rep_n_i)
                              + (src_ext_w ? times_n(d_w, rep_n_i) : 16'h0000)
                              + (code_ext_w ? (p_w + p_w) : 16'h0000)
                              + (both_ext_w ? `LPH_ONE_CYC : 16'h0000)
                              + ((dst_kind_i == LPH_DST_PERIPH) ? n_w : 16'h0000);

  // Mapped load into an I/O port; an outside source costs n-1 more.
  // port timing
  wire lph_cyc_t port_cyc_w = times_n(`LMR_PORT_PER_N, rep_n_i) + times_n(io_w, rep_n_i)
                              + (src_ext_w ? (times_n(d_w, rep_n_i) + n_w
                                 - `LPH_ONE_CYC) : 16'h0000)
                              + (code_ext_w ? (`LMR_PORT_CODE_EXT + p_w + p_w) : 16'h0000);

  // A shared single-access block costs one cycle in total.
  // shared block cycle
  wire lph_cyc_t lmr_cyc_w = (port_w ? port_cyc_w : core_cyc_w) + sh_w;

  assign cycles_o = is_lmr_i ? lmr_cyc_w : lph_cyc_w;

endmodule : lph_cycle_calc

// >>> core/lph_exec.sv
`timescale 1ns/100ps
`include "lph_consts.svh"

module lph_exec (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Instruction issue.
  input wire logic issue_i,
  input wire logic [15:0] instr_i,
  input wire logic is_lmr_i,
  input wire logic [8:0] rep_n_i,
  // Memory placement and wait states.
  input wire lph_pkg::lph_mem_t code_loc_i,
  input wire lph_pkg::lph_mem_t src_loc_i,
  input wire logic same_block_i,
  input wire lph_pkg::lph_dst_t dst_kind_i,
  input wire logic [3:0] data_wait_i,
  input wire logic [3:0] code_wait_i,
  input wire logic [3:0] io_wait_i,
  // Address sources.
  input wire logic [8:0] page_ptr_i,
  input wire logic [15:0] aux_addr_i,
  // Operand and low-half load from other instructions.
  input wire logic [15:0] operand_i,
  input wire logic prod_lo_we_i,
  input wire logic [15:0] prod_lo_i,
  // Decode results.
  output logic is_lph_o,
  output logic indirect_o,
  output logic [15:0] operand_addr_o,
  // Execution status.
  output logic busy_o,
  output logic done_o,
  output logic pc_inc_o,
  output logic status_we_o,
  output logic [15:0] cycles_o,
  // Product register.
  output logic [31:0] product_register_o
);
  import lph_pkg::*;

  // --------------------------------------------------------------------------
  // Decoding
  // --------------------------------------------------------------------------

  // Opcode match and addressing form.
  // opcode decode
  wire logic opc_hit_w = (instr_i[`LPH_OPC_HI_MSB:`LPH_OPC_HI_LSB] == `LPH_OPC_HI);
  // Bit 7 picks indirect addressing through the auxiliary register pointer.
  wire logic ind_w = instr_i[`LPH_IND_BIT];
  // address select
  // Direct addresses join the page pointer to the 7-bit offset in the word.
  wire logic [15:0] addr_w = ind_w ? aux_addr_i : {page_ptr_i, instr_i[`LPH_DMA_MSB:0]};

  // A mapped load is taken as given by the caller; only this opcode is decoded here.
  // The front end already knows a mapped load by its two-word form, so
  // checking its opcode again here would only duplicate that decode.
  wire logic accept_lph_w = opc_hit_w & ~is_lmr_i;
  wire logic accept_w = accept_lph_w | is_lmr_i;
  // A repeat count of zero is read as one execution.
  // This keeps the busy counter from starting at zero and wrapping round.
  wire logic [8:0] rep_n_w = (rep_n_i == 9'h000) ? 9'h001 : rep_n_i;

  // --------------------------------------------------------------------------
  // Cycle budget
  // --------------------------------------------------------------------------

  // Cycle total for the instruction now at issue.
  lph_cyc_t calc_cyc_w;

  // Totals are worked out in one place so both classes share the rules.
  // Sixteen bits cover the largest total that the input widths allow.
  // The total is captured at issue, so placement or wait inputs that move
  // while the instruction is in flight do not stretch or cut it.
  lph_cycle_calc u_calc (
    .is_lmr_i(is_lmr_i),
    .rep_n_i(rep_n_w),
    .code_loc_i(code_loc_i),
    .src_loc_i(src_loc_i),
    .same_block_i(same_block_i),
    .dst_kind_i(dst_kind_i),
    .data_wait_i(data_wait_i),
    .code_wait_i(code_wait_i),
    .io_wait_i(io_wait_i),
    .cycles_o(calc_cyc_w)
  );

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------

  // Sequencer state, cycle counter and the values captured at issue.
  lph_state_t state_ff;
  lph_state_t nxt_state;
  lph_cyc_t remain_ff;
  lph_cyc_t nxt_remain;
  logic lmr_ff;
  logic [15:0] addr_ff;
  logic ind_ff;
  logic [15:0] cyc_ff;
  logic [31:0] prod_ff;
  logic [31:0] nxt_prod;

  // Issue is only looked at in idle; the done cycle is a deliberate gap so
  // the program counter step can never overlap the next instruction's start.
  wire logic start_w = (state_ff == LPH_ST_IDLE) & issue_i & accept_w;
  wire logic last_w = (state_ff == LPH_ST_RUN) & (remain_ff == `LPH_ONE_CYC);

  // Issue is ignored while busy; the count of cycles sets the busy length.
  // A total of one gives a single busy cycle: the counter is loaded with one
  // and the last cycle is seen at once.
  // busy length
  always_comb begin
    nxt_state = state_ff;
    nxt_remain = remain_ff;
    case (state_ff)
      LPH_ST_IDLE: begin
        if (start_w) begin
          nxt_state = LPH_ST_RUN;
          nxt_remain = calc_cyc_w;
        end
      end
      LPH_ST_RUN: begin
        // Count down one per cycle; the value left after the last cycle is unused.
        if (last_w) begin
          nxt_state = LPH_ST_DONE;
        end
        nxt_remain = remain_ff - `LPH_ONE_CYC;
      end
      LPH_ST_DONE: begin
        // One cycle of done, then back to idle.
        nxt_state = LPH_ST_IDLE;
      end
      default: begin
        // An unused state code recovers to idle.
        nxt_state = LPH_ST_IDLE;
      end
    endcase
  end

  // The final write lands on the last busy cycle; the low half still
  // follows its own writer, which wins only for its own bits.
  // Only the high half is gated by the sequencer; a mapped load moves no
  // product data, so its last cycle leaves the register alone.
  // high half load
  always_comb begin
    nxt_prod = prod_ff;
    // Low-half writes from other logic are honoured in any state.
    if (prod_lo_we_i) begin
      nxt_prod[`LPH_PROD_HI_LSB-1:0] = prod_lo_i;
    end
    if (last_w & ~lmr_ff) begin
      nxt_prod[`LPH_PROD_HI_MSB:`LPH_PROD_HI_LSB] = operand_i;
    end
  end

  // State and counter.
  // Reset is synchronous, like the rest of the core.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= LPH_ST_IDLE;
      remain_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      remain_ff <= nxt_remain;
    end
  end

  // Captured decode and cycle total for the instruction in flight.
  // Holding these until the next take lets the pipeline read them after done.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lmr_ff <= 1'b0;
      addr_ff <= 16'h0000;
      ind_ff <= 1'b0;
      cyc_ff <= 16'h0000;
    end else if (start_w) begin
      lmr_ff <= is_lmr_i;
      addr_ff <= addr_w;
      ind_ff <= ind_w;
      cyc_ff <= calc_cyc_w;
    end
  end

  // Product register.
  // Reset clears both halves so that later readers never see an unknown value.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prod_ff <= `LPH_PROD_RST;
    end else begin
      prod_ff <= nxt_prod;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------

  // Busy and done are plain decodes of the state register, so they add no
  // flop delay; the data outputs other than is_lph_o come straight from flip-flops.
  // Decode result for the word now at the instruction input.
  assign is_lph_o = accept_lph_w;
  // Captured address and form of the last accepted instruction.
  assign indirect_o = ind_ff;
  assign operand_addr_o = addr_ff;
  assign busy_o = (state_ff == LPH_ST_RUN);
  assign done_o = (state_ff == LPH_ST_DONE);
  assign pc_inc_o = (state_ff == LPH_ST_DONE);
  assign status_we_o = 1'b0;
  assign cycles_o = cyc_ff;
  assign product_register_o = prod_ff;

endmodule : lph_exec

// >>> test/lph_exec_props.sv
`timescale 1ns/100ps
`include "lph_consts.svh"

module lph_exec_chk (
  // Clock, reset and requests.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic issue_i,
  input wire logic [15:0] instr_i,
  input wire logic is_lmr_i,
  input wire logic [15:0] operand_i,
  input wire logic prod_lo_we_i,
  // Watched outputs.
  input wire logic is_lph_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic pc_inc_o,
  input wire logic status_we_o,
  input wire logic [15:0] cycles_o,
  input wire logic [31:0] product_register_o
);
  logic mapped_ff;
  logic [15:0] busy_cnt_ff;
  wire take = issue_i && !busy_o && !done_o && (is_lmr_i || is_lph_o);

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Class of the accepted issue and a busy run length, so the total can be judged at done.
  always_ff @(posedge clk_i) begin
    if (take) begin
      mapped_ff <= is_lmr_i;
    end
    busy_cnt_ff <= busy_o ? busy_cnt_ff + 16'h0001 : 16'h0000;
  end

  sequence s_busy_end;
    busy_o ##1 !busy_o;
  endsequence

  a_take_starts_busy: assert property (take |=> busy_o)
    else $error("busy did not follow an accepted issue");
  a_busy_length: assert property (done_o |-> busy_cnt_ff == cycles_o)
    else $error("busy length differs from reported cycle total");
  a_done_pulse: assert property (s_busy_end |-> done_o ##1 !done_o)
    else $error("done is not a single pulse after busy");
  a_pc_with_done: assert property (pc_inc_o == done_o)
    else $error("program counter step not aligned with done");
  a_status_quiet: assert property (status_we_o == 1'b0)
    else $error("status write seen");
  a_low_half_kept: assert property (!prod_lo_we_i |=> $stable(product_register_o[15:0]))
    else $error("low half changed without a low write");
  a_high_half_load: assert property (done_o && !mapped_ff |->
    product_register_o[31:16] == $past(operand_i))
    else $error("high half does not hold the last operand");
  a_opcode_decode: assert property (is_lph_o == (instr_i[15:8] == 8'h75 && !is_lmr_i))
    else $error("opcode decode wrong");
  a_total_held: assert property (busy_o |=> $stable(cycles_o))
    else $error("cycle total changed while busy");
endmodule : lph_exec_chk

bind lph_exec lph_exec_chk u_chk (.clk_i, .rst_i, .issue_i, .instr_i, .is_lmr_i, .operand_i,
  .prod_lo_we_i, .is_lph_o, .busy_o, .done_o, .pc_inc_o, .status_we_o, .cycles_o,
  .product_register_o);

// >>> test/tb_top.sv
`timescale 1ns/100ps

module tb_top;
  import lph_pkg::*;
  localparam lph_mem_t rom = LPH_MEM_ROM;
  localparam lph_mem_t dar = LPH_MEM_DUAL;
  localparam lph_mem_t sar = LPH_MEM_SINGLE;
  localparam lph_mem_t ext = LPH_MEM_EXT;
  localparam lph_dst_t dcore = LPH_DST_CORE;
  localparam lph_dst_t dper = LPH_DST_PERIPH;
  localparam lph_dst_t dport = LPH_DST_PORT;
  logic clk_i, rst_i, issue_i, is_lmr_i, same_block_i, prod_lo_we_i;
  logic [15:0] instr_i, aux_addr_i, operand_i, prod_lo_i, operand_addr_o, cycles_o;
  logic [8:0] rep_n_i, page_ptr_i;
  lph_mem_t code_loc_i, src_loc_i;
  lph_dst_t dst_kind_i;
  logic [3:0] data_wait_i, code_wait_i, io_wait_i;
  logic is_lph_o, indirect_o, busy_o, done_o, pc_inc_o, status_we_o;
  logic [31:0] product_register_o;
  int fail_count, tests_run;

  lph_exec DUT (.clk_i, .rst_i, .issue_i, .instr_i, .is_lmr_i, .rep_n_i, .code_loc_i,
    .src_loc_i, .same_block_i, .dst_kind_i, .data_wait_i, .code_wait_i, .io_wait_i,
    .page_ptr_i, .aux_addr_i, .operand_i, .prod_lo_we_i, .prod_lo_i, .is_lph_o,
    .indirect_o, .operand_addr_o, .busy_o, .done_o, .pc_inc_o, .status_we_o, .cycles_o,
    .product_register_o);

  // 100 MHz core clock.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  // Issue one instruction, then count cycles up to done; the cap keeps a hang bounded.
  task automatic row(input logic m, input logic [8:0] n, input lph_mem_t c, s,
    input logic b, input lph_dst_t k, input logic [3:0] d, p, io, input logic [15:0] e);
    int cnt;
    cnt = 0;
    is_lmr_i = m;
    rep_n_i = n;
    code_loc_i = c;
    src_loc_i = s;
    same_block_i = b;
    dst_kind_i = k;
    data_wait_i = d;
    code_wait_i = p;
    io_wait_i = io;
    issue_i = 1'b1;
    @(posedge clk_i); #1;
    issue_i = 1'b0;
    while (done_o !== 1'b1 && cnt < 300) begin
      cnt++;
      @(posedge clk_i); #1;
    end
    chk("busy cycles", e, cnt);
    chk("cycles_o", e, cycles_o);
    chk("pc_inc_o", 1, pc_inc_o);
    chk("status_we_o", 0, status_we_o);
    @(posedge clk_i); #1;
  endtask : row

  task automatic t_load_data;
    prod_lo_we_i = 1'b1;
    @(posedge clk_i); #1;
    prod_lo_we_i = 1'b0;
    instr_i = 16'h7504;
    row(0, 1, dar, dar, 0, dcore, 0, 0, 0, 1);
    chk("product", 32'hf79c_9844, product_register_o);
    chk("operand_addr_o", 16'h0204, operand_addr_o);
    chk("indirect_o", 0, indirect_o);
  endtask : t_load_data

  task automatic t_single;
    row(0, 1, sar, sar, 1, dcore, 0, 0, 0, 2);
    row(0, 1, rom, ext, 0, dcore, 3, 0, 0, 4);
    row(0, 1, ext, ext, 0, dcore, 2, 1, 0, 5);
    row(0, 1, ext, dar, 0, dcore, 0, 2, 0, 3);
    row(0, 0, dar, dar, 0, dcore, 0, 0, 0, 1);
  endtask : t_single

  task automatic t_repeat;
    row(0, 7, rom, ext, 0, dcore, 2, 0, 0, 21);
    row(0, 7, ext, ext, 0, dcore, 1, 3, 0, 18);
    row(0, 5, sar, sar, 1, dcore, 0, 0, 0, 6);
    row(0, 5, ext, sar, 0, dcore, 0, 2, 0, 7);
  endtask : t_repeat

  task automatic t_mapped;
    instr_i = 16'h0000;
    row(1, 4, rom, dar, 0, dcore, 0, 0, 0, 8);
    row(1, 4, rom, dar, 0, dper, 0, 0, 0, 12);
    row(1, 3, rom, dar, 0, dport, 0, 0, 2, 15);
    row(1, 3, sar, sar, 1, dcore, 0, 0, 0, 7);
    row(1, 3, sar, sar, 1, dport, 0, 0, 1, 13);
    row(1, 2, rom, ext, 0, dcore, 3, 0, 0, 10);
    row(1, 3, rom, ext, 0, dport, 1, 0, 0, 14);
    row(1, 2, ext, dar, 0, dport, 0, 1, 1, 13);
    row(1, 2, ext, ext, 0, dcore, 1, 2, 0, 11);
  endtask : t_mapped

  task automatic t_decode;
    instr_i = 16'h75c3;
    row(0, 1, dar, dar, 0, dcore, 0, 0, 0, 1);
    chk("operand_addr_o", 16'h1234, operand_addr_o);
    chk("indirect_o", 1, indirect_o);
    chk("is_lph_o", 1, is_lph_o);
    instr_i = 16'h7445;
    issue_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    issue_i = 1'b0;
    chk("busy_o", 0, busy_o);
    chk("is_lph_o", 0, is_lph_o);
    // An issue held high into the first two busy cycles is not taken again; the total is fixed at the take.
    instr_i = 16'h7504;
    rep_n_i = 9'h003;
    issue_i = 1'b1;
    @(posedge clk_i);
    #1;
    rep_n_i = 9'h005;
    repeat (2) @(posedge clk_i);
    #1;
    chk("busy_o", 1, busy_o);
    chk("cycles_o", 3, cycles_o);
    issue_i = 1'b0;
  endtask : t_decode

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    #50000;
    fail_count++;
    wrap_up();
  end

  // Main sequence: ten reset cycles, then the scenarios.
  initial begin
    {rst_i, issue_i, is_lmr_i, same_block_i, prod_lo_we_i} = 5'b10000;
    {instr_i, rep_n_i, page_ptr_i} = {16'h0000, 9'h001, 9'h004};
    {aux_addr_i, operand_i, prod_lo_i} = {16'h1234, 16'hf79c, 16'h9844};
    code_loc_i = rom;
    src_loc_i = dar;
    dst_kind_i = dcore;
    {data_wait_i, code_wait_i, io_wait_i} = 12'h000;
    repeat (10) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    t_load_data();
    t_single();
    t_repeat();
    t_mapped();
    t_decode();
    wrap_up();
  end
endmodule : tb_top
